// >>> codec_pkg.sv
// Shared constants and types for the codec register bank and its link controller
package codec_pkg;
  localparam int SYS_CLK_MHZ       = 250;
  localparam int BIT_CLK_PERIOD_NS = 48;
  localparam int BIT_HALF_CYCLES   = BIT_CLK_PERIOD_NS * SYS_CLK_MHZ / 2000;
  localparam int CAL_TIME_NS       = 1000;
  localparam int CAL_CYCLES        = CAL_TIME_NS * SYS_CLK_MHZ / 1000;
  localparam int CAL_W             = 8;
  localparam int DIV_W             = 4;
  localparam int FRAME_BITS        = 24;
  localparam int NREG              = 10;

  // Register indices on the link
  localparam logic [6:0] IDX_LINE_IN_GAIN  = 7'h10;
  localparam logic [6:0] IDX_CD_GAIN       = 7'h12;
  localparam logic [6:0] IDX_VIDEO_GAIN    = 7'h14;
  localparam logic [6:0] IDX_AUX_GAIN      = 7'h16;
  localparam logic [6:0] IDX_PCM_OUT_GAIN  = 7'h18;
  localparam logic [6:0] IDX_CAPTURE_SRC   = 7'h1a;
  localparam logic [6:0] IDX_CAPTURE_GAIN  = 7'h1c;
  localparam logic [6:0] IDX_GENERAL_OPTS  = 7'h20;
  localparam logic [6:0] IDX_SPATIAL_DEPTH = 7'h22;
  localparam logic [6:0] IDX_POWER         = 7'h26;
  localparam logic [6:0] MIXER_IDX_LO      = 7'h10;
  localparam logic [6:0] MIXER_IDX_HI      = 7'h22;

  // Storage slots: constants lowest slot first, tables highest slot first
  localparam int         SLOT_CAP_SRC  = 5;
  localparam int         SLOT_CAP_GAIN = 6;
  localparam int         SLOT_GENERAL  = 7;
  localparam int         SLOT_SPATIAL  = 8;
  localparam int         SLOT_POWER    = 9;
  localparam logic [3:0] SLOT_NONE     = 4'hf;
  localparam logic [NREG-1:0][6:0] REG_IDX = {IDX_POWER, IDX_SPATIAL_DEPTH, IDX_GENERAL_OPTS,
    IDX_CAPTURE_GAIN, IDX_CAPTURE_SRC, IDX_PCM_OUT_GAIN, IDX_AUX_GAIN, IDX_VIDEO_GAIN,
    IDX_CD_GAIN, IDX_LINE_IN_GAIN};
  localparam logic [NREG-1:0][15:0] REG_MASK = {16'hff00, 16'h000f, 16'h2380, 16'h8f0f,
    16'h0707, 16'h9f1f, 16'h9f1f, 16'h9f1f, 16'h9f1f, 16'h9f1f};
  localparam logic [NREG-1:0][15:0] REG_RST = {16'h0000, 16'h0000, 16'h0000, 16'h8000,
    16'h0000, 16'h8808, 16'h8808, 16'h8808, 16'h8808, 16'h8808};

  // Field positions
  localparam int GAIN_MUTE_BIT  = 15;
  localparam int GAIN_L_LSB     = 8;
  localparam int GAIN_R_LSB     = 0;
  localparam int CAP_L_LSB      = 8;
  localparam int CAP_R_LSB      = 0;
  localparam int REC_MUTE_BIT   = 15;
  localparam int REC_L_LSB      = 8;
  localparam int REC_R_LSB      = 0;
  localparam int GP_SPATIAL_BIT = 13;
  localparam int GP_MONO_MIC    = 9;
  localparam int GP_MIC_B       = 8;
  localparam int GP_LOOP        = 7;
  localparam int PWR_EXT_AMP    = 15;
  localparam int PWR_ALT_OUT    = 14;
  localparam int PWR_CLK_OFF    = 13;
  localparam int PWR_LINK_OFF   = 12;
  localparam int PWR_MIX_BIAS   = 11;
  localparam int PWR_MIX_ONLY   = 10;
  localparam int PWR_PLAYBACK   = 9;
  localparam int PWR_CAPTURE    = 8;
  localparam int RDY_REF        = 3;
  localparam int RDY_ANL        = 2;
  localparam int RDY_DAC        = 1;
  localparam int RDY_ADC        = 0;

  // Gain scale in tenths of a dB
  localparam int MAX_BOOST_DB10 = 120;
  localparam int STEP_DB10      = 15;

  typedef logic signed [9:0] gain_db10_t;
  typedef enum logic [2:0] {
    SRC_MIC = 3'h0, SRC_CD = 3'h1, SRC_VIDEO = 3'h2, SRC_AUX = 3'h3,
    SRC_LINE = 3'h4, SRC_STEREO_MIX = 3'h5, SRC_MONO_MIX = 3'h6, SRC_PHONE = 3'h7
  } capture_src_t;

  // Controller register addresses and fields
  localparam logic [2:0] CA_CMD    = 3'h0;
  localparam logic [2:0] CA_WDATA  = 3'h1;
  localparam logic [2:0] CA_RDATA  = 3'h2;
  localparam logic [2:0] CA_STATUS = 3'h3;
  localparam logic [2:0] CA_CTRL   = 3'h4;
  localparam int CMD_READ_BIT = 15;
  localparam int ST_BUSY      = 0;
  localparam int ST_CODEC_RDY = 1;
  localparam int ST_REFUSED   = 2;
  localparam int ST_FLAGS_LSB = 4;
  localparam int ST_IDX_LSB   = 8;
  localparam int CTRL_COLD    = 0;
  localparam int CTRL_WARM    = 1;
endpackage

// >>> codec_link_if.sv
// Serial link between the codec register bank and its controller
`timescale 1ns/1ns
`default_nettype none
interface codec_link_if;
  logic bit_clk;
  logic sync;
  logic sdata_out;
  logic sdata_in;
  logic cold_rst_n;
  modport codec_dev (output bit_clk, output sdata_in, input sync, input sdata_out,
                     input cold_rst_n);
  modport codec_ctl (input bit_clk, input sdata_in, output sync, output sdata_out,
                     output cold_rst_n);
endinterface
`default_nettype wire

// >>> codec_mixer_power_regs.sv
// Codec end: mixer, capture and powerdown register bank behind the serial link
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module codec_mixer_power_regs
(
  // Clock and control
  input  wire logic                             i_sys_clk,
  input  wire logic                             i_rst,
  input  wire logic                             i_clk_en,
  input  wire logic                             i_direct_dac_path,
  // Serial link
  codec_link_if.codec_dev                       link,
  // Mixer inputs, index [source][1 left, 0 right]
  output var  codec_pkg::gain_db10_t [4:0][1:0] o_mix_gain_db10,
  output var  logic [4:0]                       o_mix_mute,
  // Capture path
  output var  codec_pkg::capture_src_t          o_left_capture_source,
  output var  codec_pkg::capture_src_t          o_right_capture_source,
  output var  logic [8:0]                       o_left_record_gain_db10,
  output var  logic [8:0]                       o_right_record_gain_db10,
  output var  logic                             o_record_mute,
  // Options
  output var  logic                             o_spatial_enhance_on,
  output var  logic [3:0]                       o_spatial_depth,
  output var  logic                             o_mono_from_mic,
  output var  logic                             o_mic_input_b_sel,
  output var  logic                             o_adc_to_dac_loop,
  // Power
  output var  logic                             o_ext_amp_off,
  output var  logic                             o_alt_out_off,
  output var  logic                             o_internal_clock_off,
  output var  logic [3:0]                       o_section_off,
  output var  logic [3:0]                       o_ready_flags,
  output var  logic                             o_dac_accept,
  output var  logic                             o_adc_send
);
  import codec_pkg::*;

  typedef enum logic [2:0] {
    D_IDLE = 3'b001,
    D_RX   = 3'b010,
    D_TX   = 3'b100
  } dev_fsm_t;

  typedef struct packed {
    logic                       cold_s1;
    logic                       cold_s2;
    logic                       sync_s1;
    logic                       sync_s2;
    logic                       sdo_s1;
    logic                       sdo_s2;
    logic [NREG-1:0][15:0]      regs;
    logic [3:0]                 rdy;
    logic [3:0][CAL_W-1:0]      cal_cnt;
    logic [DIV_W-1:0]           div_cnt;
    logic                       bit_clk;
    logic                       sdi;
    logic                       wake_armed;
    dev_fsm_t                   state;
    logic [4:0]                 bit_cnt;
    logic [FRAME_BITS-1:0]      sh;
  } dev_state_t;

  localparam dev_state_t DEV_RST = '{cold_s1: 1'b1, cold_s2: 1'b1, regs: REG_RST,
                                     state: D_IDLE, default: '0};

  dev_state_t            r;
  dev_state_t            n;
  logic                  rise;
  logic [3:0]            cal_en;
  logic [3:0]            slot;
  logic [FRAME_BITS-1:0] word;
  logic [15:0]           pwr;

  function automatic logic [3:0] slot_of(input logic [6:0] idx);
    slot_of = SLOT_NONE;
    for (int i = 0; i < NREG; i++)
    begin
      if (REG_IDX[i] == idx)
        slot_of = 4'(i);
    end
  endfunction

  function automatic gain_db10_t mix_gain(input logic [4:0] code);
    mix_gain = gain_db10_t'(MAX_BOOST_DB10) - gain_db10_t'(STEP_DB10 * int'(code));
  endfunction

  function automatic logic [8:0] rec_gain(input logic [3:0] code);
    rec_gain = 9'(STEP_DB10 * int'(code));
  endfunction

  always_comb
  begin
    n      = r;
    rise   = 1'b0;
    pwr    = r.regs[SLOT_POWER];
    word   = {r.sh[FRAME_BITS-2:0], r.sdo_s2};
    slot   = slot_of(word[22:16]);
    cal_en = '0;
    if (i_clk_en)
    begin
      if (!r.cold_s2)
        n = DEV_RST;
      else if (!pwr[PWR_CLK_OFF])
      begin
        n.sync_s1 = link.sync;
        n.sync_s2 = r.sync_s1;
        n.sdo_s1  = link.sdata_out;
        n.sdo_s2  = r.sdo_s1;
        // Each flag waits for its section and the reference to settle
        cal_en[RDY_REF] = !pwr[PWR_MIX_BIAS];
        cal_en[RDY_ANL] = r.rdy[RDY_REF] && !pwr[PWR_MIX_BIAS] && !pwr[PWR_MIX_ONLY];
        cal_en[RDY_DAC] = r.rdy[RDY_REF] && !pwr[PWR_PLAYBACK];
        cal_en[RDY_ADC] = r.rdy[RDY_REF] && !pwr[PWR_CAPTURE];
        for (int i = 0; i < 4; i++)
        begin
          if (!cal_en[i])
          begin
            n.cal_cnt[i] = '0;
            n.rdy[i]     = 1'b0;
          end
          else if (r.cal_cnt[i] == CAL_W'(CAL_CYCLES - 1))
            n.rdy[i] = 1'b1;
          else
            n.cal_cnt[i] = r.cal_cnt[i] + 1'b1;
        end
        if (pwr[PWR_LINK_OFF])
        begin
          // Bit clock held low; a sync pulse wakes the link
          n.bit_clk = 1'b0;
          n.div_cnt = '0;
          n.sdi     = 1'b0;
          n.state   = D_IDLE;
          if (r.sync_s2)
            n.wake_armed = 1'b1;
          else if (r.wake_armed)
          begin
            n.wake_armed                      = 1'b0;
            n.regs[SLOT_POWER][PWR_LINK_OFF]  = 1'b0;
          end
        end
        else if (r.div_cnt == DIV_W'(BIT_HALF_CYCLES - 1))
        begin
          n.div_cnt = '0;
          n.bit_clk = !r.bit_clk;
          rise      = !r.bit_clk;
        end
        else
          n.div_cnt = r.div_cnt + 1'b1;
        if (rise)
        begin
          case (r.state)
            D_IDLE:
            begin
              if (r.sync_s2)
              begin
                n.state   = D_RX;
                n.bit_cnt = '0;
              end
            end
            D_RX:
            begin
              n.sh      = word;
              n.bit_cnt = r.bit_cnt + 1'b1;
              if (r.bit_cnt == 5'(FRAME_BITS - 1))
              begin
                if (!word[23] && slot != SLOT_NONE)
                  n.regs[slot] = word[15:0] & REG_MASK[slot];
                n.sh      = {1'b1, word[22:16], 16'h0000};
                if (slot != SLOT_NONE)
                  n.sh[15:0] = (slot == 4'(SLOT_POWER)) ? {pwr[15:4], r.rdy} : r.regs[slot];
                n.sdi     = n.sh[23];
                n.bit_cnt = '0;
                n.state   = D_TX;
              end
            end
            D_TX:
            begin
              if (r.bit_cnt == 5'(FRAME_BITS - 1))
              begin
                n.sdi   = 1'b0;
                n.state = D_IDLE;
              end
              else
              begin
                n.sdi     = r.sh[22];
                n.sh      = {r.sh[FRAME_BITS-2:0], 1'b0};
                n.bit_cnt = r.bit_cnt + 1'b1;
              end
            end
            default: n.state = D_IDLE;
          endcase
        end
      end
      n.cold_s1 = link.cold_rst_n;
      n.cold_s2 = r.cold_s1;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      r <= DEV_RST;
    else
      r <= n;
  end

  assign link.bit_clk  = r.bit_clk;
  assign link.sdata_in = r.sdi;

  for (genvar g = 0; g < 5; g++)
  begin : g_mix
    assign o_mix_gain_db10[g][1] = mix_gain(r.regs[g][GAIN_L_LSB +: 5]);
    assign o_mix_gain_db10[g][0] = mix_gain(r.regs[g][GAIN_R_LSB +: 5]);
    assign o_mix_mute[g]         = r.regs[g][GAIN_MUTE_BIT];
  end

  assign o_left_capture_source    = capture_src_t'(r.regs[SLOT_CAP_SRC][CAP_L_LSB +: 3]);
  assign o_right_capture_source   = capture_src_t'(r.regs[SLOT_CAP_SRC][CAP_R_LSB +: 3]);
  assign o_left_record_gain_db10  = rec_gain(r.regs[SLOT_CAP_GAIN][REC_L_LSB +: 4]);
  assign o_right_record_gain_db10 = rec_gain(r.regs[SLOT_CAP_GAIN][REC_R_LSB +: 4]);
  assign o_record_mute            = r.regs[SLOT_CAP_GAIN][REC_MUTE_BIT];
  assign o_spatial_enhance_on     = r.regs[SLOT_GENERAL][GP_SPATIAL_BIT] && !i_direct_dac_path;
  assign o_spatial_depth          = r.regs[SLOT_SPATIAL][3:0];
  assign o_mono_from_mic          = r.regs[SLOT_GENERAL][GP_MONO_MIC];
  assign o_mic_input_b_sel        = r.regs[SLOT_GENERAL][GP_MIC_B];
  assign o_adc_to_dac_loop        = r.regs[SLOT_GENERAL][GP_LOOP];
  assign o_ext_amp_off            = r.regs[SLOT_POWER][PWR_EXT_AMP];
  assign o_alt_out_off            = r.regs[SLOT_POWER][PWR_ALT_OUT];
  assign o_internal_clock_off     = r.regs[SLOT_POWER][PWR_CLK_OFF];
  assign o_section_off            = r.regs[SLOT_POWER][PWR_MIX_BIAS:PWR_CAPTURE];
  assign o_ready_flags            = r.rdy;
  assign o_dac_accept             = r.rdy[RDY_DAC];
  assign o_adc_send               = r.rdy[RDY_ADC];
endmodule
`default_nettype wire

// >>> codec_link_ctrl.sv
// Controller end: register port for software, serial link towards the codec
`timescale 1ns/1ns
`default_nettype none
module codec_link_ctrl
(
  // Clock and control
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_clk_en,
  // Register port
  input  wire logic [2:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output var  logic [15:0] o_rdata,
  // Serial link
  codec_link_if.codec_ctl  link
);
  import codec_pkg::*;

  typedef enum logic [3:0] {
    C_IDLE = 4'b0001,
    C_SYNC = 4'b0010,
    C_CMD  = 4'b0100,
    C_RESP = 4'b1000
  } ctl_fsm_t;

  typedef struct packed {
    logic                  bclk_s1;
    logic                  bclk_s2;
    logic                  bclk_s3;
    logic                  sdi_s1;
    logic                  sdi_s2;
    logic [1:0]            ctrl;
    logic [15:0]           wdata;
    logic [15:0]           rdata;
    logic [6:0]            last_idx;
    logic                  codec_rdy;
    logic                  refused;
    logic                  is_read;
    logic [3:0]            flags;
    ctl_fsm_t              state;
    logic [4:0]            cnt;
    logic [FRAME_BITS-1:0] sh;
    logic                  sync;
    logic                  sdo;
    logic                  cold_n;
    logic [15:0]           rd_q;
  } ctl_state_t;

  localparam ctl_state_t CTL_RST = '{cold_n: 1'b1, state: C_IDLE, default: '0};

  ctl_state_t            r;
  ctl_state_t            n;
  logic                  rise;
  logic                  fall;
  logic                  busy;
  logic [FRAME_BITS-1:0] word;

  always_comb
  begin
    n    = r;
    rise = r.bclk_s2 && !r.bclk_s3;
    fall = !r.bclk_s2 && r.bclk_s3;
    busy = r.state != C_IDLE;
    word = {r.sh[FRAME_BITS-2:0], r.sdi_s2};
    if (i_clk_en)
    begin
      n.bclk_s1 = link.bit_clk;
      n.bclk_s2 = r.bclk_s1;
      n.bclk_s3 = r.bclk_s2;
      n.sdi_s1  = link.sdata_in;
      n.sdi_s2  = r.sdi_s1;
      n.rd_q    = 16'h0000;
      if (i_rd)
      begin
        case (i_addr)
          CA_WDATA:  n.rd_q = r.wdata;
          CA_RDATA:  n.rd_q = r.rdata;
          CA_STATUS: n.rd_q = {1'b0, r.last_idx, r.flags, 1'b0, r.refused, r.codec_rdy, busy};
          CA_CTRL:   n.rd_q = {14'h0000, r.ctrl};
          default:   n.rd_q = 16'h0000;
        endcase
      end
      if (i_wr && i_addr == CA_WDATA)
        n.wdata = i_wdata;
      if (i_wr && i_addr == CA_CTRL)
        n.ctrl = i_wdata[1:0];
      if (i_wr && i_addr == CA_STATUS && i_wdata[ST_REFUSED])
        n.refused = 1'b0;
      if (i_wr && i_addr == CA_CMD)
      begin
        if (busy || n.ctrl[CTRL_COLD])
          n.refused = 1'b1;
        else if (!i_wdata[CMD_READ_BIT] && i_wdata[6:0] >= MIXER_IDX_LO &&
                 i_wdata[6:0] <= MIXER_IDX_HI && !r.flags[RDY_ANL])
          n.refused = 1'b1;
        else
        begin
          n.sh      = {i_wdata[CMD_READ_BIT], i_wdata[6:0], r.wdata};
          n.is_read = i_wdata[CMD_READ_BIT];
          n.state   = C_SYNC;
          if (!i_wdata[CMD_READ_BIT] && i_wdata[6:0] == IDX_POWER)
            n.flags = 4'h0;
        end
      end
      case (r.state)
        C_IDLE: n.sync = n.ctrl[CTRL_WARM];
        C_SYNC:
        begin
          if (rise && !r.sync)
            n.sync = 1'b1;
          else if (rise)
          begin
            n.sync  = 1'b0;
            n.sdo   = r.sh[23];
            n.sh    = {r.sh[FRAME_BITS-2:0], 1'b0};
            n.cnt   = '0;
            n.state = C_CMD;
          end
        end
        C_CMD:
        begin
          if (rise && r.cnt == 5'(FRAME_BITS - 1))
          begin
            n.sdo   = 1'b0;
            n.cnt   = '0;
            n.state = C_RESP;
          end
          else if (rise)
          begin
            n.sdo = r.sh[23];
            n.sh  = {r.sh[FRAME_BITS-2:0], 1'b0};
            n.cnt = r.cnt + 1'b1;
          end
        end
        C_RESP:
        begin
          // A codec whose link stopped mid-reply can only be woken from here
          n.sync = n.ctrl[CTRL_WARM];
          if (fall)
          begin
            n.sh  = word;
            n.cnt = r.cnt + 1'b1;
            if (r.cnt == 5'(FRAME_BITS - 1))
            begin
              n.codec_rdy = word[23];
              n.last_idx  = word[22:16];
              n.rdata     = word[15:0];
              // A write echoes stale flags, so only a read refreshes the cache
              if (word[22:16] == IDX_POWER && r.is_read)
                n.flags = word[3:0];
              n.state = C_IDLE;
            end
          end
        end
        default: n.state = C_IDLE;
      endcase
      if (n.ctrl[CTRL_COLD])
      begin
        // Cold reset aborts any frame; codec state is lost
        n.state = C_IDLE;
        n.sync  = 1'b0;
        n.sdo   = 1'b0;
        n.flags = 4'h0;
      end
      n.cold_n = !n.ctrl[CTRL_COLD];
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      r <= CTL_RST;
    else
      r <= n;
  end

  assign o_rdata         = r.rd_q;
  assign link.sync       = r.sync;
  assign link.sdata_out  = r.sdo;
  assign link.cold_rst_n = r.cold_n;
endmodule
`default_nettype wire

// >>> codec_link_properties.sv
// Properties of the codec link and power status
`timescale 1ns/1ns
`default_nettype none
module codec_link_properties
(
  // Clock and reset
  input wire logic       i_sys_clk,
  input wire logic       i_rst,
  // Link and codec status
  input wire logic       bit_clk,
  input wire logic       cold_rst_n,
  input wire logic       i_direct_dac_path,
  input wire logic       o_spatial_enhance_on,
  input wire logic       o_internal_clock_off,
  input wire logic [3:0] o_section_off,
  input wire logic [3:0] o_ready_flags,
  input wire logic       o_dac_accept,
  input wire logic       o_adc_send
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  AST_DAC_GATE: assert property (o_dac_accept == o_ready_flags[1])
    else $error("dac accept not tied to flag");
  AST_ADC_GATE: assert property (o_adc_send == o_ready_flags[0])
    else $error("adc send not tied to flag");
  AST_SPATIAL_GATE: assert property (o_spatial_enhance_on |-> !i_direct_dac_path)
    else $error("enhance on in direct mode");
  AST_ADC_OFF: assert property (o_section_off[0] [*3] |-> !o_ready_flags[0])
    else $error("adc ready while off");
  AST_DAC_OFF: assert property (o_section_off[1] [*3] |-> !o_ready_flags[1])
    else $error("dac ready while off");
  AST_MIX_OFF: assert property ((|o_section_off[3:2]) [*3] |-> !o_ready_flags[2])
    else $error("mixer ready while off");
  AST_CAL_WAIT: assert property ($fell(i_rst) |-> ##240 o_ready_flags == 4'h0)
    else $error("flags rose too early");
  AST_REF_UP: assert property ($fell(i_rst) |-> ##270 o_ready_flags[3])
    else $error("reference late");
  AST_REF_ORDER: assert property ($rose(o_ready_flags[2]) |-> o_ready_flags[3])
    else $error("mixer ready before reference");
  AST_COLD_HALT: assert property (!cold_rst_n [*5] |-> !bit_clk && !o_internal_clock_off)
    else $error("codec alive in cold reset");
  AST_FROZEN: assert property ((o_internal_clock_off && cold_rst_n) [*4] |-> $stable(bit_clk))
    else $error("bit clock runs while halted");
  cover property ($rose(o_ready_flags[0]));
  cover property ($rose(o_internal_clock_off));
  cover property ($fell(cold_rst_n));
endmodule
`default_nettype wire

// >>> tb.sv
// Testbench joining both codec link ends
`timescale 1ns/1ns
`default_nettype none
module tb;
  import codec_pkg::*;
  logic                  i_sys_clk, i_rst, i_direct_dac_path, i_wr, i_rd;
  logic [2:0]            i_addr;
  logic [15:0]           i_wdata, o_rdata, q, d;
  gain_db10_t [4:0][1:0] o_mix_gain_db10;
  capture_src_t          o_left_capture_source, o_right_capture_source;
  logic [8:0]            o_left_record_gain_db10, o_right_record_gain_db10;
  logic [4:0]            o_mix_mute;
  logic [3:0]            o_spatial_depth, o_section_off, o_ready_flags;
  logic                  o_record_mute, o_spatial_enhance_on, o_mono_from_mic;
  logic                  o_mic_input_b_sel, o_adc_to_dac_loop, o_ext_amp_off, o_alt_out_off;
  logic                  o_internal_clock_off, o_dac_accept, o_adc_send;
  logic [15:0]           sh [9];
  int                    miscompares, num_checks, seed, r, k, n;
  codec_link_if lnk ();
  codec_mixer_power_regs codec_mixer_power_regs_i
  (
    .i_sys_clk, .i_rst, .i_clk_en(1'b1), .i_direct_dac_path, .link(lnk), .o_mix_gain_db10,
    .o_mix_mute, .o_left_capture_source, .o_right_capture_source, .o_left_record_gain_db10,
    .o_right_record_gain_db10, .o_record_mute, .o_spatial_enhance_on, .o_spatial_depth,
    .o_mono_from_mic, .o_mic_input_b_sel, .o_adc_to_dac_loop, .o_ext_amp_off, .o_alt_out_off,
    .o_internal_clock_off, .o_section_off, .o_ready_flags, .o_dac_accept, .o_adc_send
  );
  codec_link_ctrl codec_link_ctrl_i
  (
    .i_sys_clk, .i_rst, .i_clk_en(1'b1), .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .link(lnk)
  );
  codec_link_properties codec_link_properties_i
  (
    .i_sys_clk, .i_rst, .bit_clk(lnk.bit_clk), .cold_rst_n(lnk.cold_rst_n), .i_direct_dac_path,
    .o_spatial_enhance_on, .o_internal_clock_off, .o_section_off, .o_ready_flags,
    .o_dac_accept, .o_adc_send
  );
  initial
  begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  task automatic give_verdict;
    if (miscompares == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic bound(input int v, input int lim);
    if (v >= lim)
    begin
      miscompares++;
      give_verdict();
    end
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [2:0] a, input logic [15:0] v,
                     output logic [15:0] rv);
    @(posedge i_sys_clk);
    i_wr <= w;
    i_rd <= !w;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask
  // Sends one link frame and returns the reply data
  task automatic frame(input logic rd, input logic [6:0] x, input logic [15:0] v,
                       output logic [15:0] rv);
    int c;
    bus(1'b1, CA_WDATA, v, rv);
    bus(1'b1, CA_CMD, {rd, 8'h00, x}, rv);
    rv = 16'h0001;
    for (c = 0; c < 1000 && rv[ST_BUSY] !== 1'b0; c++)
      bus(1'b0, CA_STATUS, 16'h0000, rv);
    bound(c, 1000);
    bus(1'b0, CA_RDATA, 16'h0000, rv);
  endtask
  task automatic wait_rdy;
    int c;
    for (c = 0; c < 3000 && o_ready_flags !== 4'hf; c++)
      @(posedge i_sys_clk);
    bound(c, 3000);
  endtask
  task automatic tog(output int t);
    logic b;
    t = 0;
    repeat (100)
    begin
      b = lnk.bit_clk;
      @(posedge i_sys_clk);
      t += int'(b !== lnk.bit_clk);
    end
  endtask
  task automatic cold;
    bus(1'b1, CA_CTRL, 16'h0001, q);
    repeat (20) @(posedge i_sys_clk);
    bus(1'b1, CA_CTRL, 16'h0000, q);
  endtask
  function automatic logic [15:0] msk(input int i);
    return (i < 5) ? 16'h9f1f : (i == 5) ? 16'h0707 : (i == 6) ? 16'h8f0f :
           (i == 7) ? 16'h2380 : 16'h000f;
  endfunction
  task automatic outs(input int i, input logic [15:0] v);
    if (i < 5)
    begin
      chk("mixl", 16'(120 - 15 * int'(v[12:8])), o_mix_gain_db10[i][1]);
      chk("mixr", 16'(120 - 15 * int'(v[4:0])), o_mix_gain_db10[i][0]);
      chk("mute", v[15], o_mix_mute[i]);
    end
    else if (i == 5)
      chk("cap", {v[10:8], v[2:0]}, {o_left_capture_source, o_right_capture_source});
    else if (i == 6)
    begin
      chk("recl", 16'(15 * int'(v[11:8])), o_left_record_gain_db10);
      chk("recr", 16'(15 * int'(v[3:0])), o_right_record_gain_db10);
      chk("recmute", v[15], o_record_mute);
    end
    else if (i == 7)
      chk("opts", {v[13] & !i_direct_dac_path, v[9:7]}, {o_spatial_enhance_on, o_mono_from_mic,
          o_mic_input_b_sel, o_adc_to_dac_loop});
    else
      chk("depth", v[3:0], o_spatial_depth);
  endtask
  initial
  begin
    seed = 71;
    miscompares = 0;
    num_checks = 0;
    i_rst = 1'b1;
    i_addr = 3'h0;
    i_wdata = 16'h0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_direct_dac_path = 1'b0;
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    wait_rdy();
    frame(1'b1, IDX_POWER, 16'h0000, q);
    chk("pwr", 16'h000f, q);
    for (k = 0; k < 9; k++)
      sh[k] = (k < 5) ? 16'h8808 : (k == 6) ? 16'h8000 : 16'h0000;
    for (r = 0; r < 4; r++)
      for (k = 0; k < 9; k++)
      begin
        if (r == 0)
          outs(k, sh[k]);
        d = (r == 1) ? 16'hffff : (r == 2) ? 16'h0000 : 16'($random(seed));
        i_direct_dac_path <= r[0];
        frame(1'b0, (k < 7) ? 7'(16 + 2 * k) : 7'(18 + 2 * k), d, q);
        chk("echo", sh[k], q);
        sh[k] = d & msk(k);
        outs(k, d);
      end
    i_direct_dac_path <= 1'b0;
    for (k = 0; k < 8; k++)
    begin
      d = {5'h00, k[2:0], 5'h00, ~k[2:0]};
      frame(1'b0, IDX_CAPTURE_SRC, d, q);
      outs(5, d);
    end
    frame(1'b0, IDX_GENERAL_OPTS, 16'h2000, q);
    outs(7, 16'h2000);
    frame(1'b1, 7'h24, 16'h0000, q);
    chk("unmapped", 16'h0000, q);
    bus(1'b0, 3'h7, 16'h0000, q);
    chk("ctlmap", 16'h0000, q);
    frame(1'b0, IDX_POWER, 16'hc0f0, q);
    chk("amp", 16'h0003, {o_ext_amp_off, o_alt_out_off});
    bus(1'b1, CA_CMD, {9'h000, IDX_CD_GAIN}, q);
    bus(1'b0, CA_STATUS, 16'h0000, q);
    chk("refused", 16'h2606, q);
    bus(1'b1, CA_STATUS, 16'h0004, q);
    frame(1'b0, IDX_POWER, 16'h0f00, q);
    chk("pwrro", 16'hc00f, q);
    chk("secoff", 16'h00f0, {o_ext_amp_off, o_alt_out_off, o_section_off, o_ready_flags});
    frame(1'b0, IDX_POWER, 16'h0000, q);
    chk("pwroff", 16'h0f00, q);
    wait_rdy();
    bus(1'b1, CA_WDATA, 16'h1000, q);
    bus(1'b1, CA_CMD, {9'h000, IDX_POWER}, q);
    n = 1;
    for (r = 0; r < 20 && n != 0; r++)
      tog(n);
    bound(n, 1);
    bus(1'b1, CA_CTRL, 16'h0002, q);
    repeat (20) @(posedge i_sys_clk);
    bus(1'b1, CA_CTRL, 16'h0000, q);
    tog(n);
    chk("clkrun", 16'h0001, 16'(n > 0));
    cold();
    wait_rdy();
    bus(1'b1, CA_WDATA, 16'h2000, q);
    bus(1'b1, CA_CMD, {9'h000, IDX_POWER}, q);
    for (n = 0; n < 2000 && o_internal_clock_off !== 1'b1; n++)
      @(posedge i_sys_clk);
    bound(n, 2000);
    cold();
    chk("revive", 16'h0008, {o_internal_clock_off, o_record_mute, o_left_capture_source});
    wait_rdy();
    give_verdict();
  end
endmodule
`default_nettype wire
